// ==== logic/acs_regs.svh ====
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH
// ==========================================
// Configuration space
`define ACS_MEM_DEPTH 18
`define ACS_CFG_LAST 15'h0011
`define ACS_RST_VAL 8'h00
`define ACS_REG_CFG_A 5'h00
`define ACS_REG_CFG_B 5'h01
`define ACS_REG_CFG_C 5'h10
// ==========================================
// Field positions
`define ACS_A_SRST_BIT 7
`define ACS_A_ASCEND_BIT 5
`define ACS_A_SRST_MIRROR_BIT 0
`define ACS_B_SINGLE_BIT 7
`define ACS_B_SHORT_BIT 3
`define ACS_B_SDO_OFF_BIT 0
`define ACS_C_STRICT_BIT 5
`define ACS_C_STATUS_BIT 4
`define ACS_C_CRC_ON_BIT 1
`define ACS_C_CRC_INV_BIT 0
// ==========================================
// Multibyte entity and link framing
`define ACS_MB_LO 15'h000c
`define ACS_MB_HI 15'h000d
`define ACS_LONG_INSTR_BITS 5'h10
`define ACS_SHORT_INSTR_BITS 5'h08
`define ACS_BYTE_BITS 5'h08
`define ACS_CRC_POLY 8'h07
`define ACS_CRC_SEED 8'ha5
`endif

// ==== logic/acs_pkg.sv ====
`default_nettype none
package acs_pkg;
   // ==========================================
   // Controller states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_INSTR,
      ST_DATA,
      ST_CRC,
      ST_DROP
   } acs_state_t;

   // ==========================================
   // Controller register set
   typedef struct packed {
      acs_state_t st;
      logic [1:0] cs_s;
      logic [2:0] ck_s;
      logic [1:0] di_s;
      logic [15:0] shin;
      logic [4:0] cnt;
      logic rd;
      logic [14:0] addr;
      logic [7:0] shout;
      logic [7:0] hold;
      logic sdo;
      logic [1:0] ent_left;
      logic fault;
      logic wr_en;
      logic [14:0] wr_addr;
      logic [7:0] wr_data;
      logic srst;
   } acs_ctl_t;
endpackage : acs_pkg
`default_nettype wire

// ==== logic/acs_cfg_mem.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "acs_regs.svh"
module acs_cfg_mem #(
   parameter int DEPTH = `ACS_MEM_DEPTH
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   // Write port
   input wire logic wr_en,
   input wire logic [14:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic soft_clr,
   // Read port
   input wire logic [14:0] rd_addr,
   output logic [7:0] rd_data,
   // Option bytes
   output logic [7:0] cfg_a,
   output logic [7:0] cfg_b,
   output logic [7:0] cfg_c
);
   typedef struct packed {
      logic [DEPTH-1:0][7:0] mem;
      logic [7:0] rd;
   } acs_mem_state_t;

   acs_mem_state_t s_reg;
   acs_mem_state_t s_next;

   always_comb begin
      s_next = s_reg;
      if (wr_en && (wr_addr < 15'(DEPTH))) begin
         s_next.mem[wr_addr[4:0]] = wr_data;
      end
      // Soft reset keeps the address direction
      if (soft_clr) begin
         s_next.mem = '0;
         s_next.mem[`ACS_REG_CFG_A][`ACS_A_ASCEND_BIT] =
            s_reg.mem[`ACS_REG_CFG_A][`ACS_A_ASCEND_BIT];
      end
      s_next.rd = (rd_addr < 15'(DEPTH)) ? s_reg.mem[rd_addr[4:0]] : `ACS_RST_VAL;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_reg <= '0;
      end else if (ce) begin
         s_reg <= s_next;
      end
   end

   assign rd_data = s_reg.rd;
   assign cfg_a = s_reg.mem[`ACS_REG_CFG_A];
   assign cfg_b = s_reg.mem[`ACS_REG_CFG_B];
   assign cfg_c = s_reg.mem[`ACS_REG_CFG_C];
endmodule : acs_cfg_mem
`default_nettype wire

// ==== logic/acs_spi_ctl.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "acs_regs.svh"
// Operation
// RL1 - Instruction then data bytes, all inside one chip-select assertion.
// RL2 - Four-wire full-duplex port: select, clock, data in, data out.
// RL3 - Power-up or soft reset enables data out on general pin zero.
// RL4 - Clock idles high; outputs change on fall, sampled on rise.
// RL5 - Interface options live in configuration addresses 0x00 to 0x11.
// RL6 - Soft reset restores defaults except address direction; FIFO untouched.
// RL7 - Host issues soft reset only while the converter is idle.
// RL8 - Address counter decrements by default, increments when ascending is set.
// RL9 - Short addressing shrinks the address field from fifteen to seven bits.
// RL10 - Per-access instruction mode needs a new instruction per entity.
// RL11 - Strict access treats multibyte registers whole; partial access flags fault.
// RL12 - With check code enabled, each byte carries a check byte both ways; only data bytes carry one here, instruction bytes none.
// RL13 - Status option shifts status out during the instruction phase.
// RL14 - Instruction opens with read-high or write-low bit, then address.
// RL15 - Read data leaves most significant bit first on falling edges.
// RL16 - Streaming by default: contiguous bytes, address stepped per byte.
// RL17 - Strict entities start at high byte descending, low byte ascending.
// RL18 - Partial byte at select release is discarded; await a new instruction.
module acs_spi_ctl (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   // Serial link
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic sdi,
   output logic general_pin_zero_out,
   output logic general_pin_zero_oe,
   // Status source
   input wire logic [7:0] status_word,
   // Option and state outputs
   output logic addr_ascend,
   output logic short_addr,
   output logic per_access_instruction_mode,
   output logic strict_access,
   output logic crc_active,
   output logic status_send,
   output logic strict_fault,
   output logic soft_reset_pulse,
   output logic frame_busy
);
   acs_pkg::acs_ctl_t s_reg;
   acs_pkg::acs_ctl_t s_next;
   logic [7:0] rd_data;
   logic [7:0] cfg_a;
   logic [7:0] cfg_b;
   logic [7:0] cfg_c;
   logic rise;
   logic fall;
   logic cs_act;
   logic [7:0] rx_byte;
   logic [14:0] addr_step;
   logic [7:0] hold_crc;

   // ==========================================
   // Helpers
   function automatic logic [7:0] crc8(input logic [7:0] data);
      logic [7:0] c;
      c = `ACS_CRC_SEED ^ data;
      for (int i = 0; i < 8; i++) begin
         c = c[7] ? ((c << 1) ^ `ACS_CRC_POLY) : (c << 1);
      end
      return c;
   endfunction : crc8

   function automatic logic [14:0] step(input logic [14:0] a, input logic up);
      return up ? 15'(a + 15'h0001) : 15'(a - 15'h0001);
   endfunction : step

   // ==========================================
   // Options
   assign addr_ascend = cfg_a[`ACS_A_ASCEND_BIT];
   assign short_addr = cfg_b[`ACS_B_SHORT_BIT];
   assign per_access_instruction_mode = cfg_b[`ACS_B_SINGLE_BIT];
   assign strict_access = cfg_c[`ACS_C_STRICT_BIT];
   assign crc_active = cfg_c[`ACS_C_CRC_ON_BIT] & ~cfg_c[`ACS_C_CRC_INV_BIT];
   assign status_send = cfg_c[`ACS_C_STATUS_BIT];

   // Second sync stage against a third copy finds the edges
   assign rise = s_reg.ck_s[1] & ~s_reg.ck_s[2];
   assign fall = ~s_reg.ck_s[1] & s_reg.ck_s[2];
   assign cs_act = ~s_reg.cs_s[1];
   assign rx_byte = {s_reg.shin[6:0], s_reg.di_s[1]};
   assign addr_step = step(s_reg.addr, addr_ascend);
   assign hold_crc = crc8(s_reg.hold);

   // ==========================================
   // Controller
   always_comb begin
      logic last;
      logic done;
      logic commit;
      last = 1'b0;
      done = 1'b0;
      commit = 1'b0;
      s_next = s_reg;
      s_next.wr_en = 1'b0;
      s_next.srst = 1'b0;
      s_next.cs_s = {s_reg.cs_s[0], cs_n};
      s_next.ck_s = {s_reg.ck_s[1:0], sclk};
      s_next.di_s = {s_reg.di_s[0], sdi};
      if (!cs_act) begin
         if (s_reg.st != acs_pkg::ST_IDLE && s_reg.ent_left != 2'd0) begin
            s_next.fault = 1'b1; // [RL11]
         end
         s_next.st = acs_pkg::ST_IDLE; // [RL1] [RL18]
         s_next.cnt = '0;
         s_next.ent_left = '0;
         s_next.sdo = 1'b0;
      end else begin
         if (rise) begin
            s_next.shin = {s_reg.shin[14:0], s_reg.di_s[1]}; // [RL4]
            s_next.cnt = 5'(s_reg.cnt + 5'd1);
            last = (s_reg.cnt == 5'(`ACS_BYTE_BITS - 5'd1));
         end
         case (s_reg.st)
            acs_pkg::ST_IDLE: begin
               s_next.st = acs_pkg::ST_INSTR;
               s_next.cnt = '0;
               s_next.shout = status_send ? status_word : 8'h00; // [RL13]
            end
            acs_pkg::ST_INSTR: begin
               if (fall) begin
                  s_next.sdo = s_reg.shout[7]; // [RL13]
                  s_next.shout = {s_reg.shout[6:0], 1'b0};
               end
               if (rise && s_reg.cnt == 5'((short_addr ? `ACS_SHORT_INSTR_BITS
                     : `ACS_LONG_INSTR_BITS) - 5'd1)) begin // [RL9]
                  s_next.rd = short_addr ? s_reg.shin[6] : s_reg.shin[14]; // [RL14]
                  s_next.addr = short_addr ? {8'h00, rx_byte[6:0]}
                     : {s_reg.shin[13:0], s_reg.di_s[1]};
                  s_next.st = acs_pkg::ST_DATA;
                  s_next.cnt = '0;
               end
            end
            acs_pkg::ST_DATA: begin
               if (fall) begin
                  if (s_reg.rd && s_reg.cnt == 5'd0) begin
                     s_next.sdo = rd_data[7]; // [RL15]
                     s_next.shout = {rd_data[6:0], 1'b0};
                     s_next.hold = rd_data;
                  end else begin
                     s_next.sdo = s_reg.rd & s_reg.shout[7];
                     s_next.shout = {s_reg.shout[6:0], 1'b0};
                  end
               end
               if (last) begin
                  s_next.cnt = '0;
                  if (!s_reg.rd) begin
                     s_next.hold = rx_byte;
                  end
                  if (crc_active) begin
                     s_next.st = acs_pkg::ST_CRC; // [RL12]
                  end else begin
                     done = 1'b1;
                     commit = !s_reg.rd;
                  end
               end
            end
            acs_pkg::ST_CRC: begin
               if (fall) begin
                  if (s_reg.rd && s_reg.cnt == 5'd0) begin
                     s_next.sdo = hold_crc[7]; // [RL12]
                     s_next.shout = {hold_crc[6:0], 1'b0};
                  end else begin
                     s_next.sdo = s_reg.rd & s_reg.shout[7];
                     s_next.shout = {s_reg.shout[6:0], 1'b0};
                  end
               end
               if (last) begin
                  s_next.cnt = '0;
                  if (!s_reg.rd && rx_byte != crc8(s_reg.hold)) begin
                     s_next.st = acs_pkg::ST_DROP; // [RL12]
                  end else begin
                     s_next.st = acs_pkg::ST_DATA;
                     done = 1'b1;
                     commit = !s_reg.rd;
                  end
               end
            end
            acs_pkg::ST_DROP: begin
               s_next.sdo = 1'b0;
            end
            default: begin
               s_next.st = acs_pkg::ST_IDLE;
            end
         endcase
         if (commit) begin
            s_next.wr_en = 1'b1; // [RL16]
            s_next.wr_addr = s_reg.addr;
            s_next.wr_data = crc_active ? s_reg.hold : rx_byte;
            if (s_reg.addr == 15'(`ACS_REG_CFG_A)
                  && (s_next.wr_data[`ACS_A_SRST_BIT]
                  || s_next.wr_data[`ACS_A_SRST_MIRROR_BIT])) begin
               s_next.srst = 1'b1; // [RL6]
               s_next.fault = 1'b0;
            end
         end
         if (done) begin
            s_next.addr = addr_step; // [RL8] [RL16]
            if (s_reg.ent_left != 2'd0) begin
               s_next.ent_left = 2'(s_reg.ent_left - 2'd1);
            end else if (strict_access && (s_reg.addr == `ACS_MB_LO
                  || s_reg.addr == `ACS_MB_HI)) begin
               s_next.ent_left = 2'd1; // [RL11]
               if (s_reg.addr != (addr_ascend ? `ACS_MB_LO : `ACS_MB_HI)) begin
                  s_next.fault = 1'b1; // [RL17]
               end
            end
            if (per_access_instruction_mode && s_next.ent_left == 2'd0) begin
               s_next.st = acs_pkg::ST_INSTR; // [RL10]
               s_next.shout = status_send ? status_word : 8'h00;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_reg <= '{st: acs_pkg::ST_IDLE, cs_s: 2'b11, ck_s: 3'b111, default: '0};
      end else if (ce) begin
         s_reg <= s_next;
      end
   end

   // ==========================================
   // Configuration space, options at 0x00..0x11
   acs_cfg_mem u_mem (
      .clk(clk),
      .resetn(resetn),
      .ce(ce),
      .wr_en(s_reg.wr_en), // [RL5]
      .wr_addr(s_reg.wr_addr),
      .wr_data(s_reg.wr_data),
      .soft_clr(s_reg.srst), // [RL6]
      .rd_addr(s_reg.addr),
      .rd_data(rd_data),
      .cfg_a(cfg_a),
      .cfg_b(cfg_b),
      .cfg_c(cfg_c)
   );

   // Pin stays released between frames so it can be shared
   assign general_pin_zero_out = s_reg.sdo; // [RL2]
   assign general_pin_zero_oe = cs_act & ~cfg_b[`ACS_B_SDO_OFF_BIT]; // [RL3]
   assign strict_fault = s_reg.fault;
   assign soft_reset_pulse = s_reg.srst;
   assign frame_busy = cs_act;

   // ==========================================
   // Checks
   sequence instr_last_bit_s;
      ce && cs_act && rise && s_reg.st == acs_pkg::ST_INSTR
         && s_reg.cnt == (short_addr ? 5'd7 : 5'd15);
   endsequence

   sequence crc_bad_s;
      ce && cs_act && s_reg.st == acs_pkg::ST_CRC && rise && s_reg.cnt == 5'd7
         && !s_reg.rd && rx_byte != hold_crc;
   endsequence

   route_after_srst_a: assert property (@(posedge clk) disable iff (!resetn) // [RL3]
      (ce && s_reg.srst) |=> !cfg_b[`ACS_B_SDO_OFF_BIT])
      else $error("pin zero route not restored by soft reset");
   cs_release_a: assert property (@(posedge clk) disable iff (!resetn) // [RL18]
      (ce && s_reg.cs_s[1]) |=> (s_reg.st == acs_pkg::ST_IDLE && !s_reg.wr_en))
      else $error("frame state survived select release");
   sdo_on_fall_a: assert property (@(posedge clk) disable iff (!resetn) // [RL4]
      $changed(s_reg.sdo) |-> ($past(fall) || $past(s_reg.cs_s[1])))
      else $error("serial output changed off a falling edge");
   write_on_rise_a: assert property (@(posedge clk) disable iff (!resetn) // [RL16]
      s_reg.wr_en |-> $past(rise))
      else $error("register write not tied to a rising edge");
   addr_step_a: assert property (@(posedge clk) disable iff (!resetn) // [RL8]
      (ce && cs_act && s_reg.st == acs_pkg::ST_DATA && rise && s_reg.cnt == 5'd7
         && !crc_active) |=> s_reg.addr == $past(addr_step))
      else $error("address counter stepped the wrong way");
   short_field_a: assert property (@(posedge clk) disable iff (!resetn) // [RL9]
      instr_last_bit_s |=> s_reg.st == acs_pkg::ST_DATA)
      else $error("instruction length mismatch");
   partial_fault_a: assert property (@(posedge clk) disable iff (!resetn) // [RL11]
      (ce && s_reg.cs_s[1] && s_reg.st != acs_pkg::ST_IDLE && s_reg.ent_left != 2'd0)
         |=> s_reg.fault)
      else $error("partial entity not flagged");
   write_sdo_low_a: assert property (@(posedge clk) disable iff (!resetn) // [RL15]
      (ce && cs_act && fall && s_reg.st == acs_pkg::ST_DATA && !s_reg.rd) |=> !s_reg.sdo)
      else $error("serial output not low in write data");
   crc_drop_a: assert property (@(posedge clk) disable iff (!resetn) // [RL12]
      crc_bad_s |=> (s_reg.st == acs_pkg::ST_DROP && !s_reg.wr_en))
      else $error("bad check byte did not end the frame");
endmodule : acs_spi_ctl
`default_nettype wire

// ==== sim/acs_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Host side of the link, mode 3 master
module acs_host_model (
   // Clock reference
   input wire logic clk,
   // Link pins
   output logic cs_n,
   output logic sclk,
   output logic sdi,
   input wire logic sdo
);
   logic [7:0] tx_buf [0:5];
   logic [7:0] rx_buf [0:5];

   initial begin
      cs_n = 1'b1;
      sclk = 1'b1;
      sdi = 1'b0;
   end

   // Half period of 10 clocks keeps well above the 6 clock minimum
   task automatic half();
      repeat (10) @(negedge clk);
   endtask : half

   // Shifts nbits of tx_buf, MSB first; a short count leaves a partial byte
   task automatic frame(input int nbits);
      int i;
      repeat (4) @(negedge clk);
      cs_n = 1'b0;
      repeat (4) @(negedge clk);
      for (i = 0; i < nbits; i++) begin
         sclk = 1'b0;
         sdi = tx_buf[i / 8][7 - (i % 8)];
         half();
         sclk = 1'b1;
         rx_buf[i / 8][7 - (i % 8)] = sdo;
         half();
      end
      cs_n = 1'b1;
      // Released data line must not keep its last value
      sdi = ~sdi;
      repeat (6) @(negedge clk);
   endtask : frame
endmodule : acs_host_model
`default_nettype wire

// ==== sim/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "acs_regs.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
   typedef struct packed {
      logic [6:0] a;
      logic [7:0] d;
      logic [7:0] r;
      logic [5:0] o;
   } acs_row_t;
   // Option order: ascend, per-access, strict, check code, status, short
   localparam acs_row_t ROWS [10] = '{
      '{7'h00, 8'h20, 8'h20, 6'h20}, '{7'h00, 8'h00, 8'h00, 6'h00},
      '{7'h10, 8'h20, 8'h20, 6'h08}, '{7'h10, 8'h10, 8'h10, 6'h02},
      '{7'h10, 8'h03, 8'h03, 6'h00}, '{7'h10, 8'h00, 8'h00, 6'h00},
      '{7'h01, 8'h80, 8'h80, 6'h10}, '{7'h01, 8'h00, 8'h00, 6'h00},
      '{7'h12, 8'h55, 8'h00, 6'h00}, '{7'h11, 8'h5a, 8'h5a, 6'h00}};
   logic clk = 1'b0;
   logic resetn;
   logic cs_n, sclk, sdi, sdo_w;
   logic [7:0] status_word, d;
   logic general_pin_zero_out, general_pin_zero_oe;
   logic addr_ascend, short_addr, per_access_instruction_mode, strict_access;
   logic crc_active, status_send, strict_fault, soft_reset_pulse, frame_busy;
   logic [5:0] opts;
   logic short_m;
   int n_oe = 0;
   int oe_mark;
   int tests_run = 0;
   int n_mismatch = 0;
   int n_pulse = 0;
   int i;

   always #4 clk = ~clk;
   assign opts = {addr_ascend, per_access_instruction_mode, strict_access, crc_active,
      status_send, short_addr};
   // No pull on pin zero is known; a pull-up is assumed while it floats
   assign sdo_w = general_pin_zero_oe ? general_pin_zero_out : 1'b1;
   always @(posedge clk) if (soft_reset_pulse === 1'b1) n_pulse <= n_pulse + 1;
   always @(posedge clk) if (general_pin_zero_oe === 1'b1) n_oe <= n_oe + 1;

   acs_spi_ctl acs_spi_ctl_i (.clk(clk), .resetn(resetn), .ce(1'b1), .cs_n(cs_n),
      .sclk(sclk), .sdi(sdi), .general_pin_zero_out(general_pin_zero_out),
      .general_pin_zero_oe(general_pin_zero_oe), .status_word(status_word),
      .addr_ascend(addr_ascend), .short_addr(short_addr),
      .per_access_instruction_mode(per_access_instruction_mode),
      .strict_access(strict_access), .crc_active(crc_active), .status_send(status_send),
      .strict_fault(strict_fault), .soft_reset_pulse(soft_reset_pulse),
      .frame_busy(frame_busy));
   acs_host_model acs_host_model_i (.clk(clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
      .sdo(sdo_w));

   // ==========================================
   // Helpers
   function automatic logic [7:0] crc8(input logic [7:0] b);
      logic [7:0] c;
      int k;
      c = `ACS_CRC_SEED ^ b;
      for (k = 0; k < 8; k++) c = c[7] ? ((c << 1) ^ `ACS_CRC_POLY) : (c << 1);
      return c;
   endfunction : crc8

   task automatic xfer(input logic [47:0] v, input int nbits);
      int k;
      for (k = 0; k < 6; k++) acs_host_model_i.tx_buf[k] = v[47 - 8 * k -: 8];
      acs_host_model_i.frame(nbits);
   endtask : xfer

   task automatic wr(input logic [6:0] a, input logic [7:0] v);
      if (short_m) xfer({1'b0, a, v, 32'h0000_0000}, 16);
      else xfer({8'h00, 1'b0, a, v, 24'h00_0000}, 24);
   endtask : wr

   task automatic rd(input logic [6:0] a, output logic [7:0] v);
      if (short_m) xfer({1'b1, a, 40'h00_0000_0000}, 16);
      else xfer({8'h80, 1'b0, a, 32'h0000_0000}, 24);
      v = acs_host_model_i.rx_buf[short_m ? 1 : 2];
   endtask : rd

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : wrap_up

   initial begin
      #700000;
      n_mismatch++;
      wrap_up();
   end

   // ==========================================
   // Main sequence
   initial begin
      resetn = 1'b0;
      status_word = 8'h00;
      short_m = 1'b0;
      repeat (16) @(negedge clk);
      resetn = 1'b1;
      @(negedge clk);
      `CHK(opts, 6'h00)
      `CHK({general_pin_zero_oe, strict_fault, frame_busy}, 3'h0)
      for (i = 0; i < 10; i++) begin
         wr(ROWS[i].a, ROWS[i].d);
         `CHK(opts, ROWS[i].o)
         rd(ROWS[i].a, d);
         `CHK(d, ROWS[i].r)
      end
      wr(7'h01, 8'h08);
      `CHK(short_addr, 1'b1)
      short_m = 1'b1;
      rd(7'h01, d);
      `CHK(d, 8'h08)
      wr(7'h01, 8'h00);
      short_m = 1'b0;
      `CHK(short_addr, 1'b0)
      xfer({8'h00, 8'h05, 8'ha1, 8'ha2, 16'h0000}, 32);
      rd(7'h04, d);
      `CHK(d, 8'ha2)
      wr(7'h00, 8'h20);
      xfer({8'h00, 8'h08, 8'hb1, 8'hb2, 16'h0000}, 32);
      rd(7'h09, d);
      `CHK(d, 8'hb2)
      wr(7'h00, 8'h00);
      xfer({8'h00, 8'h04, 8'hff, 24'h00_0000}, 20);
      `CHK(frame_busy, 1'b0)
      rd(7'h04, d);
      `CHK(d, 8'ha2)
      // Streaming would push 0x0b into address 0x00 and fire a soft reset
      wr(7'h01, 8'h80);
      xfer({8'h00, 8'h02, 8'h11, 8'h00, 8'h0b, 8'h22}, 48);
      rd(7'h0b, d);
      `CHK(d, 8'h22)
      rd(7'h02, d);
      `CHK(d, 8'h11)
      wr(7'h01, 8'h00);
      wr(7'h10, 8'h20);
      xfer({8'h00, 8'h0d, 8'hc1, 8'hc2, 16'h0000}, 32);
      `CHK(strict_fault, 1'b0)
      wr(7'h0c, 8'hc3);
      `CHK(strict_fault, 1'b1)
      wr(7'h10, 8'h10);
      status_word = 8'hc3;
      rd(7'h10, d);
      `CHK(acs_host_model_i.rx_buf[0], 8'hc3)
      wr(7'h10, 8'h02);
      `CHK(crc_active, 1'b1)
      xfer({8'h00, 8'h07, 8'h5a, crc8(8'h5a), 16'h0000}, 32);
      xfer({8'h80, 8'h07, 32'h0000_0000}, 32);
      `CHK(acs_host_model_i.rx_buf[2], 8'h5a)
      `CHK(acs_host_model_i.rx_buf[3], crc8(8'h5a))
      xfer({8'h00, 8'h08, 8'h66, ~crc8(8'h66), 16'h0000}, 32);
      xfer({8'h80, 8'h08, 32'h0000_0000}, 32);
      `CHK(acs_host_model_i.rx_buf[2], 8'hb1)
      xfer({8'h00, 8'h10, 8'h00, crc8(8'h00), 16'h0000}, 32);
      `CHK(crc_active, 1'b0)
      wr(7'h00, 8'h20);
      wr(7'h01, 8'h01);
      oe_mark = n_oe;
      rd(7'h00, d);
      `CHK(n_oe - oe_mark, 0)
      // Converter side is idle here, so a soft reset is allowed
      wr(7'h00, 8'ha0);
      `CHK(n_pulse, 1)
      `CHK(opts, 6'h20)
      `CHK(strict_fault, 1'b0)
      oe_mark = n_oe;
      rd(7'h00, d);
      `CHK(d, 8'h20)
      `CHK(n_oe > oe_mark, 1'b1)
      rd(7'h05, d);
      `CHK(d, 8'h00)
      wrap_up();
   end
endmodule : testbench
`default_nettype wire
